// ---- sim/ctm_timer_checker.sv ----
// Port-level assertions for the compact timer
`timescale 1ns/1ns
`default_nettype none
module ctm_timer_checker
	import ctm_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [CTM_ADDR_W-1:0] paddr,
	input wire logic [CTM_DATA_W-1:0] pwdata,
	input wire logic [CTM_DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Timer
	input wire logic timer_out_pin,
	input wire logic timer_out_oe,
	input wire logic match_a_flag,
	input wire logic match_p_flag
);
	logic [3:0] ctrl0_reg;
	logic [7:0] ctrl1_reg;
	logic [9:0] cmpa_reg;
	// Shadow copies follow the APB commit edge only
	wire wr = psel && penable && pready && pwrite;
	wire on = ctrl0_reg[3];
	wire [1:0] mode = ctrl1_reg[7:6];
	wire [1:0] act = ctrl1_reg[5:4];
	wire lvl = ctrl1_reg[3] ^ ctrl1_reg[2];
	wire cclr = ctrl1_reg[0];
	wire [10:0] per = (ctrl0_reg[2:0] == 3'h0) ? CTM_FULL_SPAN :
		{1'b0, ctrl0_reg[2:0], 7'h00};

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl0_reg <= 4'h0;
			ctrl1_reg <= 8'h00;
			cmpa_reg <= 10'h000;
		end
		else if (wr && paddr == CTM_OFS_CTRL0)
			ctrl0_reg <= pwdata[3:0];
		else if (wr && paddr == CTM_OFS_CTRL1)
			ctrl1_reg <= pwdata[7:0];
		else if (wr && paddr == CTM_OFS_CMPA)
			cmpa_reg <= pwdata[9:0];

	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	p_pulse_a:
		assert property (match_p_flag |=> !match_p_flag)
		else $error("match_p_flag wider than one cycle");
	no_p_flag_a:
		assert property (on && $past(on) && cclr && mode != CTM_MODE_PWM
			|-> !match_p_flag) else $error("match_p_flag with A clear");
	no_a_wrap_a:
		assert property (on && $past(on) && cclr && mode != CTM_MODE_PWM &&
			cmpa_reg == 10'h000 && $stable(cmpa_reg) |-> !match_a_flag)
		else $error("match_a_flag on overflow wrap");
	timer_pin_off_a:
		assert property (mode == CTM_MODE_TIMER && $stable(ctrl1_reg) |->
			!timer_out_oe && !timer_out_pin) else $error("pin driven");
	pin_driven_a:
		assert property (mode != CTM_MODE_TIMER && $stable(ctrl1_reg) &&
			$past(presetn) |-> timer_out_oe) else $error("pin not driven");
	init_level_a:
		assert property (on && !$past(on) && mode == CTM_MODE_COMPARE |=>
			timer_out_pin == lvl) else $error("initial level wrong");
	pwm_force_a:
		assert property (on && $past(on) && mode == CTM_MODE_PWM &&
			!act[1] |-> timer_out_pin == (act[0] ? lvl : !lvl))
		else $error("forced pin level wrong");
	full_duty_a:
		assert property (on && $past(on) && mode == CTM_MODE_PWM &&
			act == 2'b10 && !ctrl1_reg[1] && {1'b0, cmpa_reg} >= per &&
			$stable(cmpa_reg) && $stable(ctrl0_reg) |-> timer_out_pin == lvl)
		else $error("full duty not active");
	pin_only_match_a:
		assert property (mode == CTM_MODE_COMPARE && on && $past(on, 2) &&
			$changed(timer_out_pin) |-> match_a_flag || $past(match_a_flag))
		else $error("pin moved without A match");
endmodule // ctm_timer_checker

bind ctm_timer ctm_timer_checker u_ctm_timer_checker (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .timer_out_pin(timer_out_pin),
	.timer_out_oe(timer_out_oe), .match_a_flag(match_a_flag),
	.match_p_flag(match_p_flag));
`default_nettype wire

// ---- sim/test_ctm_timer.sv ----
// Self-checking bench for the compact timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, x, got) \
	begin \
		samples_checked++; \
		if ((got) !== (x)) \
		begin \
			failures++; \
			$display("wrong value %s exp %0h got %0h", nm, x, got); \
		end \
	end
module test_ctm_timer
	import ctm_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic timer_out_pin, timer_out_oe, match_a_flag, match_p_flag, p0;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [32:0] aq[$], e;
	logic [3:0] ev;
	logic [9:0] r;
	int sq[$], gq[$], n, st, k, failures, samples_checked, seed, armed;

	ctm_timer u_ctm_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_out_pin(timer_out_pin), .timer_out_oe(timer_out_oe),
		.match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task summarize;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] x);
		int i;
		@(posedge pclk);
		aq.push_back(x);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 20 && !pready; i++)
			@(posedge pclk);
		if (!pready)
		begin
			failures++;
			summarize;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task go(input logic [7:0] c1, input logic [2:0] p, input logic [9:0] a);
		apb(1'b1, CTM_OFS_CTRL0, 32'h0, 33'h0);
		apb(1'b1, CTM_OFS_CTRL1, {24'h0, c1}, 33'h0);
		apb(1'b1, CTM_OFS_CMPA, {22'h0, a}, 33'h0);
		apb(1'b1, CTM_OFS_CTRL0, {28'h0, 1'b1, p}, 33'h0);
	endtask

	task ex(input int s, input int g);
		sq.push_back(s);
		gq.push_back(g);
	endtask

	task drain;
		int i;
		for (i = 0; i < 8000 && sq.size() > 0; i++)
			@(posedge pclk);
		if (sq.size() > 0)
		begin
			failures++;
			summarize;
		end
	endtask

	// ------------------------------------------------------------
	// Watchers: bus answers and event spacing
	// ------------------------------------------------------------
	always @(posedge pclk)
		if (psel && penable && pready)
		begin
			e = aq.pop_front();
			`CHK("apb", e, {pslverr, prdata})
		end

	// Kinds: 0 A flag, 1 P flag, 2 pin rise gap, 3 pin rise to fall
	always @(posedge pclk)
	begin
		ev = {p0 & !timer_out_pin, !p0 & timer_out_pin, match_p_flag,
			match_a_flag};
		p0 = timer_out_pin;
		n++;
		if (sq.size() == 0)
			armed = 0;
		if (sq.size() > 0 && armed && ev[sq[0]])
		begin
			`CHK("gap", gq[0], n)
			sq.pop_front();
			gq.pop_front();
			armed = 0;
		end
		if (sq.size() > 0)
		begin
			st = (sq[0] == 3) ? 2 : sq[0];
			if (ev[st])
			begin
				n = 0;
				armed = 1;
			end
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = 47'h0;
		presetn = 1'b0;
		seed = 32'h9612;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CTM_OFS_CTRL0, 32'h0, 33'h0);
		apb(1'b0, CTM_OFS_CTRL1, 32'h0, 33'h0);
		apb(1'b0, CTM_OFS_STATUS, 32'h0, 33'h2);
		apb(1'b0, 12'h014, 32'h0, 33'h100000000);
		r = 10'($random(seed));
		apb(1'b1, CTM_OFS_CMPA, {22'h0, r}, 33'h0);
		apb(1'b0, CTM_OFS_CMPA, 32'h0, {23'h0, r});
		apb(1'b1, CTM_OFS_COUNT, 32'h5, 33'h0);
		apb(1'b0, CTM_OFS_COUNT, 32'h0, 33'h0);
		go(8'h00, 3'h1, 10'd50);
		ex(1, 128);
		ex(0, 128);
		drain;
		go(8'h00, 3'h0, 10'd50);
		ex(0, 1024);
		drain;
		r = 10'd100 + {3'h0, r[6:0]};
		go(8'h31, 3'h1, r);
		ex(0, r);
		ex(2, 2 * r);
		ex(3, r);
		drain;
		for (k = 0; k < 3; k++)
		begin
			go({2'b00, k[1:0], k != 2, 3'b001}, 3'h1, 10'd30);
			ex(0, 30);
			drain;
			apb(1'b0, CTM_OFS_STATUS, 32'h0, {32'h1, k != 1});
		end
		go(8'hc1, 3'h1, 10'd77);
		ex(0, 77);
		drain;
		apb(1'b0, CTM_OFS_STATUS, 32'h0, 33'h0);
		go(8'ha8, 3'h2, 10'd100);
		ex(1, 256);
		ex(2, 256);
		ex(3, 100);
		drain;
		go(8'haf, 3'h1, 10'd300);
		ex(0, 300);
		ex(2, 300);
		ex(3, 172);
		drain;
		go(8'h98, 3'h1, 10'd40);
		ex(1, 128);
		drain;
		go(8'ha8, 3'h1, 10'd200);
		ex(1, 128);
		drain;
		apb(1'b0, CTM_OFS_STATUS, 32'h0, 33'h3);
		go(8'h01, 3'h1, 10'h000);
		// Long enough for a full wrap under the no-flag check
		repeat (1100) @(posedge pclk);
		summarize;
	end
endmodule // test_ctm_timer
`default_nettype wire

// ---- verilog/ctm_pkg.sv ----
// Constants and types shared by the compact timer block
`default_nettype none

package ctm_pkg;

	// ------------------------------------------------------------
	// Bus layout
	// ------------------------------------------------------------
	localparam int CTM_ADDR_W = 12;
	localparam int CTM_DATA_W = 32;
	localparam logic [11:0] CTM_OFS_CTRL0 = 12'h000;
	localparam logic [11:0] CTM_OFS_CTRL1 = 12'h004;
	localparam logic [11:0] CTM_OFS_CMPA = 12'h008;
	localparam logic [11:0] CTM_OFS_COUNT = 12'h00c;
	localparam logic [11:0] CTM_OFS_STATUS = 12'h010;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTM_C0_ON_BIT = 3;
	localparam int CTM_C0_RP_LSB = 0;
	localparam int CTM_C1_MODE_LSB = 6;
	localparam int CTM_C1_IO_LSB = 4;
	localparam int CTM_C1_OC_BIT = 3;
	localparam int CTM_C1_POL_BIT = 2;
	localparam int CTM_C1_DPX_BIT = 1;
	localparam int CTM_C1_CCLR_BIT = 0;
	localparam int CTM_ST_PIN_BIT = 0;
	localparam int CTM_ST_OE_BIT = 1;

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [3:0] CTM_CTRL0_RST = 4'h0;
	localparam logic [7:0] CTM_CTRL1_RST = 8'h00;
	localparam logic [9:0] CTM_CMPA_RST = 10'h000;
	localparam logic [9:0] CTM_COUNT_RST = 10'h000;
	// Full count span, also the meaning of a zero period code
	localparam logic [10:0] CTM_FULL_SPAN = 11'h400;
	localparam int CTM_P_SHIFT = 7;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CTM_MODE_COMPARE = 2'b00,
		CTM_MODE_UNDEF = 2'b01,
		CTM_MODE_PWM = 2'b10,
		CTM_MODE_TIMER = 2'b11
	} ctm_mode_t;

	typedef enum logic [1:0] {
		CTM_ACT_NONE = 2'b00,
		CTM_ACT_LOW = 2'b01,
		CTM_ACT_HIGH = 2'b10,
		CTM_ACT_TOGGLE = 2'b11
	} ctm_act_t;

endpackage

`default_nettype wire

// ---- verilog/ctm_timer.sv ----
// Compact 10-bit timer with compare, timer and PWM modes behind APB
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - output_invert flips pin, not in timer mode
// - pwm_role_swap picks period and duty registers
// - clear_source_sel: A match, else P/overflow
// - Select low: overflow clear only when P code zero
// - PWM ignores clear_source_sel, period clears
// - Mode 00 compare, 10 PWM, 11 timer
// - Compare, select low: both flags raised
// - Select high: only A flag raised
// - Select high, A zero: wrap, no flag
// - Compare pin moves only on A match
// - Pin action 00 leaves pin unchanged
// - timer_on rise loads initial pin level
// - Timer mode counts alike, pin undriven
// - PWM period register clears the counter
// - PWM raises A and P flags
// - Initial level sets polarity; action forces/enables
// - Swap 0: period 128 times code, 0=1024
// - Duty at or above period: always active
// - Swap 1: period from A, duty P*128
// - PWM counting continues while pin forced
// - Compare actions: none, low, high, toggle
// - PWM actions: inactive, active, waveform
// - Initial level: level or PWM polarity
// - P value compared with counter bits 9..7

module ctm_timer
	import ctm_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [CTM_ADDR_W-1:0] paddr,
	input wire logic [CTM_DATA_W-1:0] pwdata,
	output logic [CTM_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer outputs
	output logic timer_out_pin,
	output logic timer_out_oe,
	output logic match_a_flag,
	output logic match_p_flag
);

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic [3:0] ctrl0_reg;
	logic [7:0] ctrl1_reg;
	logic [9:0] cmpa_reg;
	logic [9:0] count_reg;
	logic [9:0] count_next;
	logic on_prev_reg;
	logic cmp_pin_reg;
	logic cmp_pin_next;
	logic pin_reg;
	logic oe_reg;
	logic flag_a_reg;
	logic flag_p_reg;
	logic [CTM_DATA_W-1:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	// APB handshake states
	typedef enum logic [1:0] {
		CTM_APB_IDLE = 2'b00,
		CTM_APB_ANSWER = 2'b01
	} ctm_apb_t;
	ctm_apb_t apb_state_reg;
	ctm_apb_t apb_state_next;

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	wire timer_on = ctrl0_reg[CTM_C0_ON_BIT];
	wire [2:0] compare_p_value = ctrl0_reg[CTM_C0_RP_LSB +: 3];
	wire [9:0] compare_a_value = cmpa_reg;
	wire ctm_mode_t mode_select =
		ctm_mode_t'(ctrl1_reg[CTM_C1_MODE_LSB +: 2]);
	wire ctm_act_t pin_action =
		ctm_act_t'(ctrl1_reg[CTM_C1_IO_LSB +: 2]);
	wire output_initial_level = ctrl1_reg[CTM_C1_OC_BIT];
	wire output_invert = ctrl1_reg[CTM_C1_POL_BIT];
	wire pwm_role_swap = ctrl1_reg[CTM_C1_DPX_BIT];
	wire clear_source_sel = ctrl1_reg[CTM_C1_CCLR_BIT];

	wire mode_pwm = (mode_select == CTM_MODE_PWM);
	wire mode_timer = (mode_select == CTM_MODE_TIMER);
	// Undefined code behaves as compare so the pin stays sane
	wire mode_compare = !mode_pwm && !mode_timer;

	wire on_rise = timer_on && !on_prev_reg;
	wire running = timer_on && !on_rise;

	// ------------------------------------------------------------
	// Comparators
	// ------------------------------------------------------------
	// Matches are judged on the incremented count so that a
	// period code of N gives exactly 128*N clocks between clears.
	wire [10:0] count_inc = {1'b0, count_reg} + 11'h001;
	// P code sits on counter bits 9..7
	wire [10:0] p_span = (compare_p_value == 3'h0) ? CTM_FULL_SPAN :
		{1'b0, compare_p_value, 7'h00};
	wire [10:0] a_span = (compare_a_value == 10'h000) ? CTM_FULL_SPAN :
		{1'b0, compare_a_value};
	wire overflow = (count_inc == CTM_FULL_SPAN);

	// zero A never matches in compare modes
	wire cmp_hit_a = (compare_a_value != 10'h000) &&
		(count_inc == {1'b0, compare_a_value});
	wire cmp_hit_p = (compare_p_value != 3'h0) &&
		(count_inc == p_span);
	wire pwm_hit_a = (count_inc == a_span);
	wire pwm_hit_p = (count_inc == p_span);

	wire [10:0] pwm_period = pwm_role_swap ? a_span : p_span;
	wire [10:0] pwm_duty = pwm_role_swap ? p_span :
		{1'b0, compare_a_value};

	// P flag suppressed with select high
	wire cmp_flag_a = cmp_hit_a;
	wire cmp_flag_p = cmp_hit_p && !clear_source_sel;
	// PWM flags on every comparator match
	wire ev_a = running && (mode_pwm ? pwm_hit_a : cmp_flag_a);
	wire ev_p = running && (mode_pwm ? pwm_hit_p : cmp_flag_p);

	// clear source for compare and timer modes
	// with select low, overflow clear only with zero P code
	wire cmp_clear = clear_source_sel ? (cmp_hit_a || overflow) :
		(cmp_hit_p || (overflow && compare_p_value == 3'h0));
	// PWM clears on the period register match or on overflow
	wire pwm_clear = (count_inc == pwm_period) || overflow;
	wire do_clear = mode_pwm ? pwm_clear : cmp_clear;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	// Count holds while off; restart from zero on the on edge.
	always_comb
	begin
		count_next = count_reg;
		if (on_rise)
			count_next = CTM_COUNT_RST;
		else if (running && do_clear)
			count_next = CTM_COUNT_RST;
		else if (running)
			count_next = count_inc[9:0];
	end

	// ------------------------------------------------------------
	// Pin logic
	// ------------------------------------------------------------
	always_comb
	begin
		cmp_pin_next = cmp_pin_reg;
		if (on_rise)
			cmp_pin_next = output_initial_level;
		// only A matches move the pin
		else if (running && mode_compare && cmp_hit_a)
		begin
			case (pin_action)
				CTM_ACT_NONE: cmp_pin_next = cmp_pin_reg;
				CTM_ACT_LOW: cmp_pin_next = 1'b0;
				CTM_ACT_HIGH: cmp_pin_next = 1'b1;
				CTM_ACT_TOGGLE: cmp_pin_next = !cmp_pin_reg;
				default: cmp_pin_next = cmp_pin_reg;
			endcase
		end
	end

	// Stale count of a past run must not shape the first cycle
	wire [9:0] pwm_count = on_rise ? CTM_COUNT_RST : count_reg;
	// duty at or past period stays active
	wire pwm_active = ({1'b0, pwm_count} < pwm_duty);
	wire pwm_wave = pwm_active ? output_initial_level :
		!output_initial_level;
	// PWM pin actions; code 11 parks inactive
	wire pwm_level = (pin_action == CTM_ACT_LOW) ? output_initial_level :
		(pin_action == CTM_ACT_HIGH) ? pwm_wave :
		!output_initial_level;
	wire raw_level = mode_pwm ? pwm_level : cmp_pin_next;
	// inversion applies to driven modes only
	// timer mode leaves the pin undriven
	wire pin_next = mode_timer ? 1'b0 : (raw_level ^ output_invert);
	wire oe_next = !mode_timer;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	// Map: 000 control 0, 004 control 1, 008 compare A,
	// 00c count (read only), 010 status (read only)
	// Control 0: [3] timer on, [2:0] P code
	// Control 1: [7:6] mode, [5:4] pin action, [3] initial level,
	// [2] invert, [1] role swap, [0] clear select
	// Status: [1] pin driven, [0] pin level
	// One wait state: pready rises in the second access cycle.
	wire apb_req = psel && penable && (apb_state_reg == CTM_APB_IDLE);
	wire apb_done = psel && penable && (apb_state_reg == CTM_APB_ANSWER);
	wire [11:0] ofs = paddr[11:0];
	wire hit_c0 = (ofs == CTM_OFS_CTRL0);
	wire hit_c1 = (ofs == CTM_OFS_CTRL1);
	wire hit_a = (ofs == CTM_OFS_CMPA);
	wire hit_cnt = (ofs == CTM_OFS_COUNT);
	wire hit_st = (ofs == CTM_OFS_STATUS);
	wire mapped = hit_c0 || hit_c1 || hit_a || hit_cnt || hit_st;
	wire wr_en = apb_done && pwrite && mapped;

	wire [CTM_DATA_W-1:0] rd_mux =
		hit_c0 ? {28'h0, ctrl0_reg} :
		hit_c1 ? {24'h0, ctrl1_reg} :
		hit_a ? {22'h0, cmpa_reg} :
		hit_cnt ? {22'h0, count_reg} :
		hit_st ? {30'h0, oe_reg, pin_reg} :
		32'h00000000;

	// ------------------------------------------------------------
	// APB handshake
	// ------------------------------------------------------------
	// Answer follows the first access cycle, then back to idle
	always_comb
	begin
		apb_state_next = apb_state_reg;
		case (apb_state_reg)
			CTM_APB_IDLE:
				if (apb_req)
					apb_state_next = CTM_APB_ANSWER;
			CTM_APB_ANSWER:
				apb_state_next = CTM_APB_IDLE;
			default:
				apb_state_next = CTM_APB_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			apb_state_reg <= CTM_APB_IDLE;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end
		else
		begin
			apb_state_reg <= apb_state_next;
			pready_reg <= apb_req;
			pslverr_reg <= apb_req && !mapped;
			prdata_reg <= (apb_req && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// Counter and status are not writable here; timer on is written via control 0
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl0_reg <= CTM_CTRL0_RST;
			ctrl1_reg <= CTM_CTRL1_RST;
			cmpa_reg <= CTM_CMPA_RST;
		end
		else if (wr_en)
		begin
			if (hit_c0)
				ctrl0_reg <= pwdata[3:0];
			if (hit_c1)
				ctrl1_reg <= pwdata[7:0];
			if (hit_a)
				cmpa_reg <= pwdata[9:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_reg <= CTM_COUNT_RST;
			on_prev_reg <= 1'b0;
			cmp_pin_reg <= 1'b0;
			pin_reg <= 1'b0;
			oe_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			on_prev_reg <= timer_on;
			cmp_pin_reg <= cmp_pin_next;
			pin_reg <= pin_next;
			oe_reg <= oe_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_a_reg <= 1'b0;
			flag_p_reg <= 1'b0;
		end
		else
		begin
			flag_a_reg <= ev_a;
			flag_p_reg <= ev_p;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign timer_out_pin = pin_reg;
	assign timer_out_oe = oe_reg;
	assign match_a_flag = flag_a_reg;
	assign match_p_flag = flag_p_reg;

endmodule // ctm_timer

`default_nettype wire
